// ==== design/dpm_data_pointer_memory_map.v ====
`timescale 1ns/1ns
// Notes on behaviour
// - SRAM holds word addresses 0000h to 0BFFh, 6KB in all.
// - Pointer as source loads from memory; as destination stores to it.
// - Two independent 16-bit data pointers, plain or auto step indirect.
// - Increment: add one after a read, before a write.
// - Decrement: subtract one after a read, before a write.
// - Frame address is base plus offset, 16-bit unsigned.
// - Frame step changes offset by one, before write, after read.
// - Frame step touches offset only; no carry into base.
// - Code pointer only reads program memory; steps after the read.
// - SRAM access via data or frame pointer completes in one clock.
// - Code pointer program read takes two clocks.
// - Stack is 16-bit words in SRAM indexed by stack pointer.
// - Stack pointer resets to 03F0h.
// - Call, push, vectoring: decrement pointer, then write.
// - Return, pop: read at pointer, then increment pointer.
// - Pop with priority restore is a pop that also sets priority bits.
// - All 16 pointer bits decode memory in word and byte modes.
// - Program memory maps into data space over 8000h to FFFFh when running from utility ROM.
// - Page select picks one page in byte mode, a page pair in word mode.
// - Word/byte selects reset to word; both widths are supported.
// - Upper half is utility ROM, or program pages when running from ROM.
// - Code pointer upper select 0: byte reads hit lower 64KB.
// - Code pointer upper select 1: byte reads hit upper 64KB.
`include "dpm_map.vh"

module dpm_data_pointer_memory_map #(
   parameter SRAM_WORDS = `DPM_SRAM_WORDS
) (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output wire        hreadyout,
   output wire        hresp,
   output wire [31:0] hrdata,
   // Core request and answer
   input  wire        core_req,
   input  wire [2:0]  core_op,
   input  wire [1:0]  core_ptr,
   input  wire [1:0]  core_mode,
   input  wire [15:0] core_wdata,
   input  wire        exec_from_urom,
   output wire        core_busy,
   output wire        core_ack,
   output wire [15:0] core_rdata,
   output wire        prio_restore,
   // Program memory read port
   output wire        prog_rd,
   output wire [15:0] prog_addr,
   input  wire [15:0] prog_rdata,
   // Utility ROM read port
   output wire        urom_rd,
   output wire [15:0] urom_addr,
   input  wire [15:0] urom_rdata
);

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_EXT  = 2'b10;
   localparam       IDX_W   = $clog2(SRAM_WORDS);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // silent wrap
   function [15:0] step16;
      input [15:0] v;
      input [1:0]  mode;
      begin
         case (mode)
            `DPM_MODE_INC: step16 = v + 16'h0001;
            `DPM_MODE_DEC: step16 = v - 16'h0001;
            default:       step16 = v;
         endcase
      end
   endfunction

   function [7:0] lane8;
      input [15:0] w;
      input        hi;
      begin
         lane8 = hi ? w[15:8] : w[7:0];
      end
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg [15:0]               dp0_r, dp1_r, fbase_r, foffs_r, cp_r, sp_r;
   reg [15:0]               dp0_nxt, dp1_nxt, fbase_nxt, foffs_nxt, cp_nxt, sp_nxt;
   reg [`DPM_CTRL_W-1:0]    ctrl_r, ctrl_nxt;
   reg [1:0]                state_r;
   reg [15:0]               last_addr_r;
   reg                      ack_r;
   reg [15:0]               rdata_r;
   reg                      prio_r;
   reg                      ext_rd_r;
   reg                      ext_prog_r;
   reg [15:0]               ext_addr_r;
   reg                      ext_byte_r;
   reg                      ext_lane_r;
   reg                      ext_cp_r;
   reg [1:0]                ext_mode_r;
   reg                      ext_pop_with_priority_restore_r;
   reg [15:0]               mem [0:SRAM_WORDS-1];

   reg                      ahb_wr_r;
   reg [7:0]                ahb_off_r;
   reg [31:0]               hrdata_r;

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   wire        accept    = core_req & state_r[0];
   wire        is_push   = (core_op == `DPM_OP_PUSH);
   wire        is_pop_with_priority_restore   = (core_op == `DPM_OP_POP_WITH_PRIORITY_RESTORE);
   wire        is_pop    = (core_op == `DPM_OP_POP) | is_pop_with_priority_restore;
   wire        is_store  = (core_op == `DPM_OP_STORE);
   wire        is_load   = (core_op == `DPM_OP_LOAD);
   wire        use_sp    = is_push | is_pop;
   wire        ptr_cp    = ~use_sp & (core_ptr == `DPM_PTR_CP);

   reg  [15:0] sel_ptr;
   reg  [15:0] stepped;
   reg  [15:0] addr;
   reg         byte_mode;
   always @* begin
      sel_ptr   = dp0_r;
      byte_mode = 1'b0;
      case (core_ptr)
         `DPM_PTR_DP0: begin
            sel_ptr   = dp0_r;
            byte_mode = ~ctrl_r[`DPM_CTRL_WBS_DP0];
         end
         `DPM_PTR_DP1: begin
            sel_ptr   = dp1_r;
            byte_mode = ~ctrl_r[`DPM_CTRL_WBS_DP1];
         end
         `DPM_PTR_FP: begin
            sel_ptr   = foffs_r;
            byte_mode = ~ctrl_r[`DPM_CTRL_WBS_FP];
         end
         default: begin
            sel_ptr   = cp_r;
            byte_mode = ~ctrl_r[`DPM_CTRL_WBS_CP];
         end
      endcase
      // pre-step for writes, post-step for reads
      stepped = step16(sel_ptr, core_mode);
      addr    = is_store ? stepped : sel_ptr;
      if (core_ptr == `DPM_PTR_FP)
         addr = fbase_r + addr;
      if (use_sp) begin
         byte_mode = 1'b0;
         addr      = is_push ? (sp_r - 16'h0001) : sp_r;
      end
   end

   // full 16-bit decode in both widths
   wire [15:0] word_idx  = byte_mode ? {1'b0, addr[15:1]} : addr;
   wire        hit_sram  = ~ptr_cp & ~addr[15] & ({16'h0000, word_idx} < SRAM_WORDS);
   wire        hit_upper = ~ptr_cp & addr[15];
   wire        to_prog   = ptr_cp | (hit_upper & exec_from_urom);
   wire        ext_go    = accept & (is_load | is_pop) & (ptr_cp | hit_upper);

   // program page mapping into data space
   wire [1:0]  cda      = ctrl_r[`DPM_CTRL_CDA_HI:`DPM_CTRL_CDA_LO];
   wire [15:0] map_word = byte_mode ? {cda, addr[14:1]} : {cda[1], addr[14:0]};
   // code pointer page select in byte mode only
   wire [15:0] cp_word  = byte_mode ? {ctrl_r[`DPM_CTRL_CPA], cp_r[15:1]} : cp_r;
   wire [15:0] ext_word = ptr_cp ? cp_word : (to_prog ? map_word : word_idx);

   // Index cut to the array depth; out-of-range words are gated by hit_sram
   wire [IDX_W-1:0] mem_idx = word_idx[IDX_W-1:0];
   wire [15:0] sram_q   = mem[mem_idx];

   // ------------------------------------------------------------
   // SRAM storage
   // ------------------------------------------------------------
   always @(posedge hclk) begin
      if (accept & (is_store | is_push) & hit_sram) begin
         if (byte_mode & addr[0])
            mem[mem_idx] <= {core_wdata[7:0], sram_q[7:0]};
         else if (byte_mode)
            mem[mem_idx] <= {sram_q[15:8], core_wdata[7:0]};
         else
            mem[mem_idx] <= core_wdata;
      end
   end

   // ------------------------------------------------------------
   // Pointer next values
   // ------------------------------------------------------------
   wire wr_en = ahb_wr_r;
   always @* begin
      dp0_nxt   = dp0_r;
      dp1_nxt   = dp1_r;
      fbase_nxt = fbase_r;
      foffs_nxt = foffs_r;
      cp_nxt    = cp_r;
      sp_nxt    = sp_r;
      ctrl_nxt  = ctrl_r;
      if (wr_en) begin
         case (ahb_off_r)
            `DPM_OFF_DP0:   dp0_nxt   = hwdata[15:0];
            `DPM_OFF_DP1:   dp1_nxt   = hwdata[15:0];
            `DPM_OFF_FBASE: fbase_nxt = hwdata[15:0];
            `DPM_OFF_FOFFS: foffs_nxt = hwdata[15:0];
            `DPM_OFF_CP:    cp_nxt    = hwdata[15:0];
            `DPM_OFF_SP:    sp_nxt    = hwdata[15:0];
            `DPM_OFF_CTRL:  ctrl_nxt  = hwdata[`DPM_CTRL_W-1:0];
            default:        ctrl_nxt  = ctrl_r;
         endcase
      end
      // Core updates win over a register write in the same cycle
      if (accept) begin
         if (is_push)
            sp_nxt = sp_r - 16'h0001;
         else if (is_pop)
            sp_nxt = sp_r + 16'h0001;
         else if (core_ptr == `DPM_PTR_DP0)
            dp0_nxt = stepped;
         else if (core_ptr == `DPM_PTR_DP1)
            dp1_nxt = stepped;
         else if (core_ptr == `DPM_PTR_FP)
            foffs_nxt = stepped;
      end
      // code pointer steps once its read completes
      if (state_r[1] & ext_cp_r)
         cp_nxt = step16(cp_r, ext_mode_r);
   end

   // ------------------------------------------------------------
   // Registers and access sequencing
   // ------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp0_r       <= 16'h0000;
         dp1_r       <= 16'h0000;
         fbase_r     <= 16'h0000;
         foffs_r     <= 16'h0000;
         cp_r        <= 16'h0000;
         sp_r        <= `DPM_RST_SP;
         ctrl_r      <= `DPM_RST_CTRL;
         state_r     <= ST_IDLE;
         last_addr_r <= 16'h0000;
         ack_r       <= 1'b0;
         rdata_r     <= 16'h0000;
         prio_r      <= 1'b0;
         ext_rd_r    <= 1'b0;
         ext_prog_r  <= 1'b0;
         ext_addr_r  <= 16'h0000;
         ext_byte_r  <= 1'b0;
         ext_lane_r  <= 1'b0;
         ext_cp_r    <= 1'b0;
         ext_mode_r  <= `DPM_MODE_PLAIN;
         ext_pop_with_priority_restore_r  <= 1'b0;
      end else begin
         dp0_r   <= dp0_nxt;
         dp1_r   <= dp1_nxt;
         fbase_r <= fbase_nxt;
         foffs_r <= foffs_nxt;
         cp_r    <= cp_nxt;
         sp_r    <= sp_nxt;
         ctrl_r  <= ctrl_nxt;
         ack_r   <= 1'b0;
         prio_r  <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (ext_go) begin
                  state_r     <= ST_EXT;
                  ext_rd_r    <= 1'b1;
                  ext_prog_r  <= to_prog;
                  ext_addr_r  <= ext_word;
                  ext_byte_r  <= byte_mode;
                  ext_lane_r  <= ptr_cp ? cp_r[0] : addr[0];
                  ext_cp_r    <= ptr_cp;
                  ext_mode_r  <= core_mode;
                  ext_pop_with_priority_restore_r  <= is_pop_with_priority_restore;
                  last_addr_r <= addr;
               end else if (accept) begin
                  ack_r       <= 1'b1;
                  prio_r      <= is_pop_with_priority_restore;
                  last_addr_r <= addr;
                  if (!hit_sram)
                     rdata_r <= 16'h0000;
                  else if (byte_mode)
                     rdata_r <= {8'h00, lane8(sram_q, addr[0])};
                  else
                     rdata_r <= sram_q;
               end
            end
            ST_EXT: begin
               // second cycle closes the program or utility ROM read
               state_r  <= ST_IDLE;
               ext_rd_r <= 1'b0;
               ack_r    <= 1'b1;
               prio_r   <= ext_pop_with_priority_restore_r;
               if (ext_byte_r)
                  rdata_r <= {8'h00, lane8(ext_prog_r ? prog_rdata : urom_rdata,
                                           ext_lane_r)};
               else
                  rdata_r <= ext_prog_r ? prog_rdata : urom_rdata;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------
   wire       ahb_go = hsel & htrans[1] & hready;
   reg [31:0] rd_mux;
   always @* begin
      case (haddr[7:0])
         `DPM_OFF_DP0:   rd_mux = {16'h0000, dp0_r};
         `DPM_OFF_DP1:   rd_mux = {16'h0000, dp1_r};
         `DPM_OFF_FBASE: rd_mux = {16'h0000, fbase_r};
         `DPM_OFF_FOFFS: rd_mux = {16'h0000, foffs_r};
         `DPM_OFF_CP:    rd_mux = {16'h0000, cp_r};
         `DPM_OFF_SP:    rd_mux = {16'h0000, sp_r};
         `DPM_OFF_CTRL:  rd_mux = {25'h0000000, ctrl_r};
         `DPM_OFF_STAT:  rd_mux = {last_addr_r, 15'h0000, state_r[1]};
         default:        rd_mux = 32'h00000000;
      endcase
      if (haddr[31:8] != 24'h000000)
         rd_mux = 32'h00000000;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ahb_wr_r  <= 1'b0;
         ahb_off_r <= 8'h00;
         hrdata_r  <= 32'h00000000;
      end else begin
         ahb_wr_r  <= ahb_go & hwrite & (haddr[31:8] == 24'h000000);
         ahb_off_r <= haddr[7:0];
         if (ahb_go & ~hwrite)
            hrdata_r <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign hrdata       = hrdata_r;
   assign core_busy    = state_r[1];
   assign core_ack     = ack_r;
   assign core_rdata   = rdata_r;
   assign prio_restore = prio_r;
   assign prog_rd      = ext_rd_r & ext_prog_r;
   assign prog_addr    = ext_addr_r;
   assign urom_rd      = ext_rd_r & ~ext_prog_r;
   assign urom_addr    = ext_addr_r;

endmodule // dpm_data_pointer_memory_map

// ==== design/dpm_map.vh ====
`ifndef DPM_MAP_VH
`define DPM_MAP_VH

// Register byte offsets on the AHB-Lite bus
`define DPM_OFF_DP0      8'h00
`define DPM_OFF_DP1      8'h04
`define DPM_OFF_FBASE    8'h08
`define DPM_OFF_FOFFS    8'h0c
`define DPM_OFF_CP       8'h10
`define DPM_OFF_SP       8'h14
`define DPM_OFF_CTRL     8'h18
`define DPM_OFF_STAT     8'h1c

// Control register fields
`define DPM_CTRL_WBS_DP0 0
`define DPM_CTRL_WBS_DP1 1
`define DPM_CTRL_WBS_FP  2
`define DPM_CTRL_WBS_CP  3
`define DPM_CTRL_CDA_LO  4
`define DPM_CTRL_CDA_HI  5
`define DPM_CTRL_CPA     6
`define DPM_CTRL_W       7

// Reset values and SRAM depth
`define DPM_RST_CTRL     7'h0f
`define DPM_RST_SP       16'h03f0
`define DPM_SRAM_WORDS   3072

// Core operation codes
`define DPM_OP_LOAD      3'h0
`define DPM_OP_STORE     3'h1
`define DPM_OP_PUSH      3'h2
`define DPM_OP_POP       3'h3
`define DPM_OP_POP_WITH_PRIORITY_RESTORE      3'h4

// Pointer selects
`define DPM_PTR_DP0      2'h0
`define DPM_PTR_DP1      2'h1
`define DPM_PTR_FP       2'h2
`define DPM_PTR_CP       2'h3

// Addressing modes
`define DPM_MODE_PLAIN   2'h0
`define DPM_MODE_INC     2'h1
`define DPM_MODE_DEC     2'h2

`endif

// ==== dv/dpm_checker_sva.sv ====
`timescale 1ns/1ns
`include "dpm_map.vh"
module dpm_checker (
   // Clock and reset
   input wire       hclk,
   input wire       hresetn,
   // Watched ports
   input wire       hreadyout,
   input wire       hresp,
   input wire       core_req,
   input wire [2:0] core_op,
   input wire [1:0] core_ptr,
   input wire       core_busy,
   input wire       core_ack,
   input wire       prio_restore,
   input wire       prog_rd,
   input wire       urom_rd
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire take = core_req && !core_busy;
   wire pop_with_priority_restore = take && core_op == `DPM_OP_POP_WITH_PRIORITY_RESTORE;
   wire one  = take && core_op != `DPM_OP_LOAD && core_op <= `DPM_OP_POP_WITH_PRIORITY_RESTORE;
   wire cp   = take && core_op == `DPM_OP_LOAD && core_ptr == `DPM_PTR_CP;
   sequence ext_wait_s;
      core_busy && prog_rd && !core_ack;
   endsequence
   sequence ext_done_s;
      core_ack && !core_busy && !prog_rd;
   endsequence
   bus_okay_a:
      assert property (hreadyout && !hresp) else $error("bus waited or erred");
   short_ack_a:
      assert property (one |=> core_ack && !core_busy) else $error("short access late");
   cp_read_a:
      assert property (cp |=> ext_wait_s ##1 ext_done_s) else $error("code read not two cycles");
   busy_once_a:
      assert property (core_busy |=> !core_busy) else $error("busy held too long");
   busy_ext_a:
      assert property (core_busy |-> (prog_rd || urom_rd) && !core_ack) else $error("busy idle");
   ack_cause_a:
      assert property (core_ack |-> $past(take) || $past(core_busy)) else $error("stray ack");
   prio_set_a:
      assert property (pop_with_priority_restore |=> prio_restore && core_ack) else $error("priority not restored");
   prio_only_a:
      assert property (prio_restore |-> $past(pop_with_priority_restore)) else $error("priority without pop");
   rd_pulse_a:
      assert property (prog_rd |=> !prog_rd) else $error("program read too long");
endmodule // dpm_checker
bind dpm_data_pointer_memory_map dpm_checker u_chk (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .core_req(core_req), .core_op(core_op), .core_ptr(core_ptr), .core_busy(core_busy),
   .core_ack(core_ack), .prio_restore(prio_restore), .prog_rd(prog_rd), .urom_rd(urom_rd));

// ==== dv/dpm_mem_model.sv ====
`timescale 1ns/1ns
module dpm_mem_model (
   // Memory read ports
   input  wire        prog_rd,
   input  wire [15:0] prog_addr,
   output wire [15:0] prog_rdata,
   input  wire        urom_rd,
   input  wire [15:0] urom_addr,
   output wire [15:0] urom_rdata
);
   // full program range
   // Idle output is inverted so a stale read never matches
   assign prog_rdata = (prog_addr ^ 16'h5a5a) ^ {16{!prog_rd}};
   assign urom_rdata = (urom_addr ^ 16'ha5c3) ^ {16{!urom_rd}};
endmodule // dpm_mem_model

// ==== dv/tb_data_pointer_memory_map.sv ====
`timescale 1ns/1ns
`include "dpm_map.vh"
module tb_data_pointer_memory_map;
   reg         hclk = 1'b0;
   reg         hresetn = 1'b0;
   reg         hsel = 1'b0;
   reg  [31:0] haddr = 32'h0;
   reg  [1:0]  htrans = 2'h0;
   reg         hwrite = 1'b0;
   reg  [31:0] hwdata = 32'h0;
   reg         core_req = 1'b0;
   reg  [2:0]  core_op = 3'h0;
   reg  [1:0]  core_ptr = 2'h0;
   reg  [1:0]  core_mode = 2'h0;
   reg  [15:0] core_wdata = 16'h0;
   reg         exec_from_urom = 1'b0;
   wire        hreadyout, hresp, core_busy, core_ack, prio_restore, prog_rd, urom_rd;
   wire [31:0] hrdata;
   wire [15:0] core_rdata, prog_addr, prog_rdata, urom_addr, urom_rdata;
   integer     fails = 0;
   integer     checks = 0;
   integer     k;
   reg  [31:0] rd;
   reg  [15:0] pa, ua, e;
   reg         pr;
   always #5 hclk = ~hclk;
   dpm_data_pointer_memory_map dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
      .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .core_req(core_req), .core_op(core_op), .core_ptr(core_ptr), .core_mode(core_mode),
      .core_wdata(core_wdata), .exec_from_urom(exec_from_urom), .core_busy(core_busy),
      .core_ack(core_ack), .core_rdata(core_rdata), .prio_restore(prio_restore),
      .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
      .urom_rd(urom_rd), .urom_addr(urom_addr), .urom_rdata(urom_rdata));
   dpm_mem_model mem (.prog_rd(prog_rd), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
      .urom_rd(urom_rd), .urom_addr(urom_addr), .urom_rdata(urom_rdata));
   task finish_test;
      begin
         if (fails == 0 && checks > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [47:0] nm, input [31:0] ex, input [31:0] got);
      begin
         checks = checks + 1;
         if (got !== ex) begin
            fails = fails + 1;
            $display("[ERR] %0s exp %h got %h", nm, ex, got);
         end
      end
   endtask
   task tmo(input integer n);
      begin
         if (n > 20) begin
            fails = fails + 1;
            finish_test;
         end
      end
   endtask
   // Wait for the edge where ready is sampled high
   task rdy;
      integer n;
      begin
         n = 0;
         @(posedge hclk);
         while (hreadyout !== 1'b1) begin
            n = n + 1;
            tmo(n);
            @(posedge hclk);
         end
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         haddr <= {24'h0, a};
         hwrite <= w;
         htrans <= 2'h2;
         rdy;
         htrans <= 2'h0;
         hsel <= 1'b0;
         hwdata <= d;
         rdy;
         rd = hrdata;
      end
   endtask
   task cr(input [2:0] op, input [1:0] ptr, input [1:0] mode, input [15:0] wd);
      integer n;
      begin
         core_req <= 1'b1;
         core_op <= op;
         core_ptr <= ptr;
         core_mode <= mode;
         core_wdata <= wd;
         pa = 16'hffff;
         ua = 16'hffff;
         n = 0;
         @(posedge hclk);
         core_req <= 1'b0;
         @(posedge hclk);
         while (core_ack !== 1'b1) begin
            if (prog_rd === 1'b1) pa = prog_addr;
            if (urom_rd === 1'b1) ua = urom_addr;
            n = n + 1;
            tmo(n);
            @(posedge hclk);
         end
         pr = prio_restore;
         rd = {16'h0, core_rdata};
      end
   endtask
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, `DPM_OFF_SP, 32'h0);
      chk("sp", 32'h03f0, rd);
      bus(1'b0, `DPM_OFF_CTRL, 32'h0);
      chk("ctrl", 32'h0f, rd);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmap", 32'h0, rd);
      bus(1'b1, `DPM_OFF_DP0, 32'h10);
      cr(`DPM_OP_STORE, `DPM_PTR_DP0, `DPM_MODE_PLAIN, 16'h1111);
      cr(`DPM_OP_STORE, `DPM_PTR_DP0, `DPM_MODE_INC, 16'h2222);
      cr(`DPM_OP_LOAD, `DPM_PTR_DP0, `DPM_MODE_DEC, 16'h0);
      chk("pre_in", 32'h2222, rd);
      cr(`DPM_OP_LOAD, `DPM_PTR_DP0, `DPM_MODE_INC, 16'h0);
      chk("post_d", 32'h1111, rd);
      bus(1'b0, `DPM_OFF_DP0, 32'h0);
      chk("dp0", 32'h11, rd);
      cr(`DPM_OP_STORE, `DPM_PTR_DP1, `DPM_MODE_DEC, 16'h5555);
      bus(1'b0, `DPM_OFF_DP1, 32'h0);
      chk("dp1", 32'hffff, rd);
      cr(`DPM_OP_LOAD, `DPM_PTR_DP1, `DPM_MODE_INC, 16'h0);
      chk("uadr", 32'hffff, {16'h0, ua});
      chk("urom", 32'h5a3c, rd);
      bus(1'b1, `DPM_OFF_CTRL, 32'h0e);
      bus(1'b1, `DPM_OFF_DP0, 32'h21);
      cr(`DPM_OP_STORE, `DPM_PTR_DP0, `DPM_MODE_PLAIN, 16'h00ab);
      bus(1'b1, `DPM_OFF_CTRL, 32'h0f);
      for (k = 0; k < 3; k = k + 1) begin
         bus(1'b1, `DPM_OFF_DP0, (k == 0) ? 32'h10 : 32'h0bfe + k);
         if (k > 0) cr(`DPM_OP_STORE, `DPM_PTR_DP0, `DPM_MODE_PLAIN, 16'h6666);
         cr(`DPM_OP_LOAD, `DPM_PTR_DP0, `DPM_MODE_PLAIN, 16'h0);
         chk("sram", (k == 0) ? 32'hab11 : (k == 1) ? 32'h6666 : 32'h0, rd);
      end
      bus(1'b1, `DPM_OFF_FBASE, 32'h100);
      bus(1'b1, `DPM_OFF_FOFFS, 32'hffff);
      cr(`DPM_OP_STORE, `DPM_PTR_FP, `DPM_MODE_INC, 16'h3333);
      bus(1'b0, `DPM_OFF_FBASE, 32'h0);
      chk("fbase", 32'h100, rd);
      bus(1'b0, `DPM_OFF_FOFFS, 32'h0);
      chk("foffs", 32'h0, rd);
      bus(1'b1, `DPM_OFF_DP0, 32'h100);
      cr(`DPM_OP_LOAD, `DPM_PTR_DP0, `DPM_MODE_PLAIN, 16'h0);
      chk("frame", 32'h3333, rd);
      cr(`DPM_OP_PUSH, 2'h0, 2'h0, 16'h4444);
      bus(1'b0, `DPM_OFF_SP, 32'h0);
      chk("sp_psh", 32'h03ef, rd);
      bus(1'b1, `DPM_OFF_DP0, 32'h03ef);
      cr(`DPM_OP_LOAD, `DPM_PTR_DP0, `DPM_MODE_PLAIN, 16'h0);
      chk("stack", 32'h4444, rd);
      cr(`DPM_OP_POP_WITH_PRIORITY_RESTORE, 2'h0, 2'h0, 16'h0);
      chk("pop", 32'h4444, rd);
      chk("prio", 32'h1, {31'h0, pr});
      bus(1'b0, `DPM_OFF_SP, 32'h0);
      chk("sp_pop", 32'h03f0, rd);
      for (k = 0; k < 2; k = k + 1) begin
         bus(1'b1, `DPM_OFF_CTRL, {25'h0, k[0], 6'h07});
         bus(1'b1, `DPM_OFF_CP, 32'h0003);
         cr(`DPM_OP_LOAD, `DPM_PTR_CP, `DPM_MODE_INC, 16'h0);
         e = {k[0], 15'h0001} ^ 16'h5a5a;
         chk("cp_adr", {16'h0, k[0], 15'h0001}, {16'h0, pa});
         chk("cp_dat", {24'h0, e[15:8]}, rd);
         bus(1'b0, `DPM_OFF_CP, 32'h0);
         chk("cp", 32'h4, rd);
      end
      exec_from_urom <= 1'b1;
      bus(1'b1, `DPM_OFF_DP0, 32'h8005);
      for (k = 0; k < 2; k = k + 1) begin
         bus(1'b1, `DPM_OFF_CTRL, {26'h0, k[0], 5'h0f});
         cr(`DPM_OP_LOAD, `DPM_PTR_DP0, `DPM_MODE_PLAIN, 16'h0);
         e = {k[0], 15'h0005} ^ 16'h5a5a;
         chk("pg_adr", {16'h0, k[0], 15'h0005}, {16'h0, pa});
         chk("pg_dat", {16'h0, e}, rd);
      end
      bus(1'b1, `DPM_OFF_CTRL, 32'h3e);
      cr(`DPM_OP_LOAD, `DPM_PTR_DP0, `DPM_MODE_PLAIN, 16'h0);
      chk("pgbadr", 32'hc002, {16'h0, pa});
      chk("pgbdat", 32'h9a, rd);
      bus(1'b0, `DPM_OFF_STAT, 32'h0);
      chk("stat", 32'h80050000, rd);
      finish_test;
   end
endmodule // tb_data_pointer_memory_map
